// [logic/cfgdl_pkg.sv]
package cfgdl_pkg;
  // Clock and timing
  localparam int  CLK_HZ            = 50_000_000;
  localparam real FIRST_STATE_MS    = 0.5;
  localparam int  FIRST_STATE_CYC   = int'(FIRST_STATE_MS * CLK_HZ / 1000.0);
  localparam real STATE_LOAD_US     = 10.0;
  localparam int  STATE_LOAD_CYC    = int'(STATE_LOAD_US * CLK_HZ / 1_000_000.0);
  localparam real LOCKOUT_V         = 2.5;

  // Register addresses on the device link
  localparam logic [15:0] ADDR_UPDCTL     = 16'h0090;
  localparam logic [15:0] ADDR_RELOAD     = 16'h00d8;
  localparam logic [15:0] ADDR_SEQCTL     = 16'h0093;
  localparam logic [15:0] NV_CFG_BASE     = 16'hf800;
  localparam logic [15:0] NV_CFG_LAST     = 16'hf89f;
  localparam logic [15:0] NV_SEQ_BASE     = 16'hfa00;
  localparam logic [15:0] NV_SEQ_LAST     = 16'hfbff;
  localparam logic [15:0] ADDR_ERASE      = 16'h00fe;
  localparam int          PAGE_BYTES      = 32;
  localparam int          CFG_BYTES       = 160;
  localparam int          SEQ_BYTES       = 512;
  localparam int          SEQ_STATES      = 63;

  // Update control and reload bit positions
  localparam int UPD_LIVE  = 0;
  localparam int UPD_PULSE = 1;
  localparam int UPD_ERASE = 2;
  localparam int RELOAD_GO = 0;

  // Host APB register offsets
  localparam logic [7:0] APB_CMD    = 8'h00;
  localparam logic [7:0] APB_ADDR   = 8'h04;
  localparam logic [7:0] APB_WDATA  = 8'h08;
  localparam logic [7:0] APB_STATUS = 8'h0c;
  localparam logic [7:0] APB_RDATA  = 8'h10;

  localparam logic [31:0] APB_RESET_ZERO = 32'h0000_0000;
endpackage : cfgdl_pkg

// [logic/cfgdl_if.sv]
`timescale 1ns/1ns
// Byte-level register link: request/answer handshake replacing bus framing
interface cfgdl_if;
  logic        req;
  logic        wr;
  logic [15:0] addr;
  logic [7:0]  wdata;
  logic        ack;
  logic        nack;
  logic [7:0]  rdata;
  modport dev  (input req, wr, addr, wdata, output ack, nack, rdata);
  modport host (output req, wr, addr, wdata, input ack, nack, rdata);
endinterface : cfgdl_if

// [logic/cfgdl_device.sv]
`timescale 1ns/1ns
module cfgdl_device
  import cfgdl_pkg::*;
#(
  parameter int FIRST_CYC = FIRST_STATE_CYC
) (
  // Clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // Supply monitor
  input  wire logic        supply_ok,
  // Sequencing engine side
  input  wire logic        seq_exit,
  // Link
  cfgdl_if.dev             lnk,
  // Configuration outputs
  output logic [CFG_BYTES*8-1:0] cfg_active,
  output logic             dl_done,
  output logic             seq_valid,
  output logic [63:0]      seq_word,
  output logic [5:0]       seq_state
);
  typedef enum logic [2:0] {
    ST_WAIT = 3'b000, ST_COPY = 3'b001, ST_XFER = 3'b010,
    ST_RUN  = 3'b011, ST_SEQLD = 3'b100
  } cfgdl_st_t;

  typedef struct packed {
    cfgdl_st_t   st;
    logic [7:0]  idx;
    logic [19:0] tmr;
    logic        first_pending;
    logic        reload_pending;
    logic        engine_on;
    logic [7:0]  updctl;
    logic [7:0]  ptr;
    logic        ack;
    logic        nack;
    logic [7:0]  rdata;
    logic        done;
    logic        sv;
    logic [63:0] sw;
    logic [5:0]  ss;
  } cfgdl_dev_t;

  cfgdl_dev_t r, n;
  // Memories held outside the struct
  logic [7:0] nv_cfg [CFG_BYTES];
  logic [7:0] nv_seq [SEQ_BYTES];
  logic [7:0] stage  [CFG_BYTES];
  logic [7:0] active [CFG_BYTES];

  function automatic logic in_rng(input logic [15:0] a, lo, hi);
    return (a >= lo) && (a <= hi);
  endfunction : in_rng

  wire logic is_cfg_ram = (lnk.addr < 16'(CFG_BYTES));
  wire logic is_nv_cfg  = in_rng(lnk.addr, NV_CFG_BASE, NV_CFG_LAST);
  wire logic is_nv_seq  = in_rng(lnk.addr, NV_SEQ_BASE, NV_SEQ_LAST);
  wire logic take       = lnk.req && !r.ack && !r.nack;
  wire logic commit     = take && lnk.wr && lnk.addr == ADDR_UPDCTL
                          && lnk.wdata[UPD_PULSE];
  wire logic reload_req = take && lnk.wr && lnk.addr == ADDR_RELOAD
                          && lnk.wdata[RELOAD_GO] && r.done;
  wire logic [7:0] cidx = lnk.addr[7:0];
  wire logic [8:0] sidx = lnk.addr[8:0];
  wire logic [8:0] sbase = {r.ss, 3'b000};

  always_comb begin
    n = r;
    n.ack  = 1'b0;
    n.nack = 1'b0;
    n.updctl[UPD_PULSE] = 1'b0;
    // A reload taken mid state load is kept until the engine is back in RUN
    if (reload_req) n.reload_pending = 1'b1;
    unique case (r.st)
      ST_WAIT: if (supply_ok) begin
        n.st  = ST_COPY;
        n.idx = 8'h00;
      end
      ST_COPY: begin
        if (r.idx == 8'(CFG_BYTES - 1)) n.st = ST_XFER;
        else n.idx = r.idx + 8'h01;
      end
      ST_XFER: begin
        n.st   = ST_RUN;
        n.done = 1'b1;
        if (!r.engine_on) begin
          n.first_pending = 1'b1;
          n.tmr = 20'(FIRST_CYC);
        end
      end
      ST_RUN: begin
        if (r.reload_pending || reload_req) begin
          n.reload_pending = 1'b0;
          n.st  = ST_COPY;
          n.idx = 8'h00;
        end else if (r.first_pending) begin
          if (r.tmr <= 20'd1) begin
            n.first_pending = 1'b0;
            n.engine_on = 1'b1;
            n.ss  = 6'd0;
            n.st  = ST_SEQLD;
            n.tmr = 20'(STATE_LOAD_CYC);
          end else n.tmr = r.tmr - 20'd1;
        end else if (r.engine_on && seq_exit) begin
          n.ss  = (r.ss == 6'(SEQ_STATES - 1)) ? 6'd0 : r.ss + 6'd1;
          n.sv  = 1'b0;
          n.st  = ST_SEQLD;
          n.tmr = 20'(STATE_LOAD_CYC);
        end
      end
      ST_SEQLD: begin
        if (r.tmr <= 20'd1) begin
          n.sv = 1'b1;
          for (int b = 0; b < 8; b++) n.sw[b*8 +: 8] = nv_seq[sbase + 9'(b)];
          n.st = ST_RUN;
        end else n.tmr = r.tmr - 20'd1;
      end
      default: n.st = ST_WAIT;
    endcase
    n.rdata = r.rdata;
    if (take) begin
      n.ptr = lnk.addr[7:0];
      if (!r.done) n.nack = 1'b1;
      else if (is_nv_seq && r.engine_on) n.nack = 1'b1;
      else begin
        n.ack = 1'b1;
        if (lnk.wr) begin
          if (lnk.addr == ADDR_UPDCTL) begin
            n.updctl = lnk.wdata & 8'h05;
          end else if (lnk.addr == ADDR_SEQCTL) begin
            n.engine_on = lnk.wdata[0];
          end
        // Control registers sit inside the RAM range, so they decode first
        end else if (lnk.addr == ADDR_UPDCTL) n.rdata = r.updctl;
        else if (lnk.addr == ADDR_SEQCTL) n.rdata = {7'h00, r.engine_on};
        else if (is_cfg_ram) n.rdata = active[cidx];
        else if (is_nv_cfg) n.rdata = nv_cfg[cidx];
        else if (is_nv_seq) n.rdata = nv_seq[sidx];
        else n.rdata = 8'h00;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      r <= '0;
    end else begin
      r <= n;
    end
  end

  // Memory updates
  wire logic wr_ok = take && lnk.wr && r.done;
  always_ff @(posedge pclk) begin
    if (r.st == ST_COPY) stage[r.idx] <= nv_cfg[r.idx];
    else if (wr_ok && is_cfg_ram) stage[cidx] <= lnk.wdata;
    if (r.st == ST_XFER || commit && r.done) begin
      for (int i = 0; i < CFG_BYTES; i++) active[i] <= stage[i];
    end else if (wr_ok && is_cfg_ram && r.updctl[UPD_LIVE]) begin
      active[cidx] <= lnk.wdata;
    end
    if (wr_ok && is_nv_cfg) nv_cfg[cidx] <= lnk.wdata;
    else if (wr_ok && lnk.addr == ADDR_ERASE && r.updctl[UPD_ERASE]) begin
      for (int i = 0; i < PAGE_BYTES; i++)
        if (lnk.wdata[2:0] * PAGE_BYTES + i < CFG_BYTES)
          nv_cfg[lnk.wdata[2:0] * PAGE_BYTES + i] <= 8'hff;
    end
    if (wr_ok && is_nv_seq && !r.engine_on) nv_seq[sidx] <= lnk.wdata;
  end

  always_comb begin
    for (int i = 0; i < CFG_BYTES; i++) cfg_active[i*8 +: 8] = active[i];
  end
  assign lnk.ack   = r.ack;
  assign lnk.nack  = r.nack;
  assign lnk.rdata = r.rdata;
  assign dl_done   = r.done;
  assign seq_valid = r.sv;
  assign seq_word  = r.sw;
  assign seq_state = r.ss;
endmodule : cfgdl_device

// [logic/cfgdl_host.sv]
`timescale 1ns/1ns
// Link master driven by APB-visible command registers
module cfgdl_host
  import cfgdl_pkg::*;
(
  // Clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  // Link
  cfgdl_if.host            lnk
);
  typedef struct packed {
    logic        busy;
    logic        wr;
    logic [15:0] addr;
    logic [7:0]  wdata;
    logic [7:0]  rdata;
    logic        nacked;
    logic        done;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
  } cfgdl_host_t;
  cfgdl_host_t r, n;

  wire logic acc     = psel && penable && !r.pready;
  // Writes land only at the edge that completes the transfer
  wire logic wr_fire = psel && penable && pwrite && r.pready;

  always_comb begin
    n = r;
    n.pready  = 1'b0;
    n.pslverr = 1'b0;
    if (wr_fire) begin
      unique case (paddr)
        APB_ADDR:  n.addr = pwdata[15:0];
        APB_WDATA: n.wdata = pwdata[7:0];
        APB_CMD: if (!r.busy) begin
          n.busy = 1'b1;
          n.wr   = pwdata[0];
          n.done = 1'b0;
        end
        default: ;
      endcase
    end
    if (acc) begin
      n.pready = 1'b1;
      if (pwrite) begin
        n.pslverr = (paddr != APB_ADDR) && (paddr != APB_WDATA) && (paddr != APB_CMD)
                    && (paddr != APB_STATUS) && (paddr != APB_RDATA);
      end else begin
        unique case (paddr)
          APB_ADDR:   n.prdata = {16'h0000, r.addr};
          APB_WDATA:  n.prdata = {24'h000000, r.wdata};
          APB_STATUS: n.prdata = {29'h0, r.nacked, r.done, r.busy};
          APB_RDATA:  n.prdata = {24'h000000, r.rdata};
          APB_CMD:    n.prdata = APB_RESET_ZERO;
          default: begin
            n.prdata  = APB_RESET_ZERO;
            n.pslverr = 1'b1;
          end
        endcase
      end
    end
    // Retry is software's job: a refusal just ends the request
    if (r.busy && (lnk.ack || lnk.nack)) begin
      n.busy   = 1'b0;
      n.done   = 1'b1;
      n.nacked = lnk.nack;
      if (lnk.ack && !r.wr) n.rdata = lnk.rdata;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) r <= '0;
    else r <= n;
  end

  // Request stands while busy; the answer cycle itself blocks a second take
  assign lnk.req   = r.busy;
  assign lnk.wr    = r.wr;
  assign lnk.addr  = r.addr;
  assign lnk.wdata = r.wdata;
  assign prdata    = r.prdata;
  assign pready    = r.pready;
  assign pslverr   = r.pslverr;
endmodule : cfgdl_host

// [bench/cfgdl_properties.sv]
`timescale 1ns/1ns
module cfgdl_properties
  import cfgdl_pkg::*;
#(
  parameter int FIRST_CYC = 20
) (
  // Clock and reset
  input wire logic        pclk,
  input wire logic        presetn,
  // Link
  input wire logic        req,
  input wire logic        wr,
  input wire logic [15:0] addr,
  input wire logic [7:0]  wdata,
  input wire logic        ack,
  input wire logic        nack,
  // Device status
  input wire logic        dl_done,
  input wire logic        seq_valid,
  input wire logic [5:0]  seq_state
);
  localparam int LO = FIRST_CYC - 2;
  localparam int HI = FIRST_CYC + 510;
  logic eng_on;
  wire  take = req && !ack && !nack;

  // Engine counts as running from first load until halted over the link
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) eng_on <= 1'b0;
    else if ($rose(seq_valid)) eng_on <= 1'b1;
    else if (take && wr && addr == ADDR_SEQCTL && !wdata[0]) eng_on <= 1'b0;
  end

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_nack_early: assert property (take && !dl_done |=> nack)
    else $error("request before download not refused");
  a_answer_next: assert property (take |=> ack ^ nack)
    else $error("request not answered next cycle");
  a_answer_pulse: assert property ((ack || nack) |=> !(ack || nack))
    else $error("answer longer than one cycle");
  a_first_quiet: assert property ($rose(dl_done) |-> !seq_valid [*8])
    else $error("first state loaded too early");
  a_first_delay: assert property ($rose(dl_done) |-> ##[LO:HI] $rose(seq_valid))
    else $error("first state not loaded in time");
  a_state_range: assert property (seq_state <= 6'd62)
    else $error("state index out of range");
  a_state_step: assert property ($changed(seq_state) |->
    seq_state == $past(seq_state) + 6'd1 || seq_state == 6'd0)
    else $error("state index skipped");
  a_seq_refuse: assert property (take && eng_on && addr >= NV_SEQ_BASE
    && addr <= NV_SEQ_LAST |=> nack)
    else $error("state store reached while engine runs");
endmodule : cfgdl_properties

// [bench/cfgdl_bench.sv]
`timescale 1ns/1ns
module cfgdl_bench;
  import cfgdl_pkg::*;
  logic        pclk = 0, presetn = 0, supply_ok = 0, seq_exit = 0;
  logic        psel = 0, penable = 0, pwrite = 0, pready, pslverr, err;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata;
  logic [CFG_BYTES*8-1:0] cfg_active;
  logic        dl_done, seq_valid;
  logic [63:0] seq_word;
  logic [5:0]  seq_state;
  int          bad_count = 0, n_checks = 0;

  cfgdl_if lnk();
  cfgdl_host i_cfgdl_host (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .lnk(lnk));
  cfgdl_device #(.FIRST_CYC(20)) i_cfgdl_device (.pclk(pclk), .presetn(presetn),
    .supply_ok(supply_ok), .seq_exit(seq_exit), .lnk(lnk), .cfg_active(cfg_active),
    .dl_done(dl_done), .seq_valid(seq_valid), .seq_word(seq_word), .seq_state(seq_state));
  cfgdl_properties #(.FIRST_CYC(20)) i_cfgdl_properties (.pclk(pclk), .presetn(presetn),
    .req(lnk.req), .wr(lnk.wr), .addr(lnk.addr), .wdata(lnk.wdata), .ack(lnk.ack),
    .nack(lnk.nack), .dl_done(dl_done), .seq_valid(seq_valid), .seq_state(seq_state));

  initial begin
    forever #10 pclk = ~pclk;
  end

  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    n_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] q);
    @(posedge pclk);
    psel <= 1; pwrite <= w; paddr <= a; pwdata <= d; penable <= 0;
    @(posedge pclk) penable <= 1;
    do @(posedge pclk); while (pready !== 1'b1);
    q = prdata;
    err = pslverr;
    psel <= 0; penable <= 0;
  endtask : apb

  task automatic link(input logic w, input logic [15:0] a, input logic [7:0] d,
                      output logic [7:0] q, output logic nk);
    logic [31:0] r;
    int i;
    apb(1, APB_ADDR, {16'h0, a}, r);
    apb(1, APB_WDATA, {24'h0, d}, r);
    apb(1, APB_CMD, {31'h0, w}, r);
    i = 0;
    do begin apb(0, APB_STATUS, 32'h0, r); i++; end while (r[0] === 1'b1 && i < 50);
    chk(r[0], 1'b0);
    nk = r[2];
    apb(0, APB_RDATA, 32'h0, r);
    q = r[7:0];
  endtask : link

  // Retry while the device refuses the read with a nack, up to 20 tries; a reload copy is not refused
  task automatic rd(input logic [15:0] a, output logic [7:0] q);
    logic nk;
    int i;
    i = 0;
    do begin link(0, a, 8'h00, q, nk); i++; end while (nk !== 1'b0 && i < 20);
    chk(nk, 1'b0);
  endtask : rd

  task automatic lw(input logic [15:0] a, input logic [7:0] d);
    logic [7:0] q;
    logic nk;
    link(1, a, d, q, nk);
  endtask : lw

  task automatic t_powerup;
    logic [7:0] q;
    logic nk;
    int i;
    repeat (40) @(posedge pclk);
    chk(dl_done, 0);
    link(0, 16'h0000, 8'h00, q, nk);
    chk(nk, 1);
    supply_ok <= 1;
    i = 0;
    while (dl_done !== 1'b1 && i < 5000) begin @(posedge pclk); i++; end
    chk(dl_done, 1);
    link(0, 16'h0000, 8'h00, q, nk);
    chk(nk, 0);
  endtask : t_powerup

  task automatic t_latches;
    logic [7:0] q;
    lw(ADDR_UPDCTL, 8'h01);
    lw(16'h0003, 8'h3c);
    chk(cfg_active[31:24], 8'h3c);
    lw(ADDR_UPDCTL, 8'h00);
    lw(16'h0003, 8'hc3);
    chk(cfg_active[31:24], 8'h3c);
    lw(ADDR_UPDCTL, 8'h02);
    chk(cfg_active[31:24], 8'hc3);
    rd(ADDR_UPDCTL, q);
    chk(q[1], 0);
  endtask : t_latches

  task automatic t_reload;
    logic [7:0] q;
    int i;
    lw(ADDR_UPDCTL, 8'h01);
    lw(16'h0005, 8'ha5);
    lw(16'hf805, 8'h5a);
    chk(cfg_active[47:40], 8'ha5);
    lw(ADDR_RELOAD, 8'h01);
    // The recopy may wait behind a state load in progress
    i = 0;
    while (cfg_active[47:40] !== 8'h5a && i < 2000) begin @(posedge pclk); i++; end
    chk(cfg_active[47:40], 8'h5a);
    rd(16'h0005, q);
    chk(q, 8'h5a);
    lw(ADDR_UPDCTL, 8'h00);
    lw(ADDR_ERASE, 8'h00);
    rd(16'hf805, q);
    chk(q, 8'h5a);
    lw(ADDR_UPDCTL, 8'h04);
    lw(ADDR_ERASE, 8'h00);
    rd(16'hf805, q);
    chk(q, 8'hff);
  endtask : t_reload

  task automatic t_engine;
    logic [7:0] q;
    logic [31:0] pr;
    logic nk;
    int i;
    i = 0;
    while (seq_valid !== 1'b1 && i < 2000) begin @(posedge pclk); i++; end
    link(0, NV_SEQ_BASE, 8'h00, q, nk);
    chk(nk, 1);
    seq_exit <= 1;
    i = 0;
    while (seq_state !== 6'd1 && i < 2000) begin @(posedge pclk); i++; end
    seq_exit <= 0;
    chk(seq_state, 6'd1);
    lw(ADDR_SEQCTL, 8'h00);
    lw(NV_SEQ_BASE, 8'h11);
    link(0, NV_SEQ_BASE, 8'h00, q, nk);
    chk(nk, 0);
    chk(q, 8'h11);
    apb(0, 8'h14, 32'h0, pr);
    chk(err, 1);
    chk(pr, 32'h0000_0000);
  endtask : t_engine

  task automatic conclude;
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : conclude

  initial begin
    #2_000_000;
    bad_count++;
    conclude();
  end

  initial begin
    repeat (4) @(posedge pclk);
    presetn <= 1;
    t_powerup();
    t_latches();
    t_reload();
    t_engine();
    conclude();
  end
endmodule : cfgdl_bench
